// >>> rcc_params.svh
`ifndef RCC_PARAMS_SVH
`define RCC_PARAMS_SVH

// ==========================================================
// Addresses
`define RCC_RESET_VECTOR 16'hFFFE
`define RCC_ERASED_WORD 16'hFFFF
`define RCC_PERIPH_TOP 16'h01FF

// ==========================================================
// Register numbers
`define RCC_PC 4'h0
`define RCC_SP 4'h1
`define RCC_SR 4'h2
`define RCC_CG 4'h3

// ==========================================================
// Status register fields
`define RCC_SR_C 0
`define RCC_SR_Z 1
`define RCC_SR_N 2
`define RCC_SR_OFF 4
`define RCC_SR_V 8
`define RCC_SLEEP_BITS 16'h00F0
`define RCC_SR_RESET 16'h0000

`endif

// >>> rcc_pkg.sv
package rcc_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [9:0] {
    ST_VEC = 10'h001,
    ST_FETCH = 10'h002,
    ST_SEXT = 10'h004,
    ST_SRD = 10'h008,
    ST_DEXT = 10'h010,
    ST_DRD = 10'h020,
    ST_EXEC = 10'h040,
    ST_MWR = 10'h080,
    ST_PUSH = 10'h100,
    ST_SLEEP = 10'h200
  } rcc_state_e;

  // ==========================================================
  // Dual-operand opcodes
  typedef enum logic [3:0] {
    OP_MOV = 4'h4,
    OP_ADD = 4'h5,
    OP_ADDC = 4'h6,
    OP_SUBC = 4'h7,
    OP_SUB = 4'h8,
    OP_CMP = 4'h9,
    OP_DADD = 4'hA,
    OP_BIT = 4'hB,
    OP_BIC = 4'hC,
    OP_BIS = 4'hD,
    OP_XOR = 4'hE,
    OP_AND = 4'hF
  } rcc_op_e;

  // ==========================================================
  // Single-operand opcodes
  typedef enum logic [2:0] {
    OP_RRC = 3'h0,
    OP_SWPB = 3'h1,
    OP_RRA = 3'h2,
    OP_SXT = 3'h3,
    OP_PUSH = 3'h4,
    OP_CALL = 3'h5,
    OP_RETI = 3'h6
  } rcc_op2_e;

  // ==========================================================
  // Core state
  typedef struct packed {
    rcc_state_e state;
    logic [15:0][15:0] regs;
    logic [15:0] ir;
    logic [15:0] srcVal;
    logic [15:0] dstVal;
    logic [15:0] ea;
    logic [15:0] dea;
    logic [15:0] memAddr;
    logic [15:0] memWdata;
    logic memRd;
    logic memWr;
    logic memByte;
    logic fault;
  } rcc_core_s;

endpackage : rcc_pkg

// >>> rcc_alu.sv
`timescale 1ns/100ps

module rcc_alu
  import rcc_pkg::*;
(
  input wire logic fmt2,
  input wire logic [3:0] opc,
  input wire logic byteOp,
  input wire logic [15:0] src,
  input wire logic [15:0] dst,
  input wire logic cIn,
  output logic [15:0] res,
  output logic [3:0] flags,
  output logic flagsEn,
  output logic wrEn
);

  function automatic logic top(input logic [15:0] x, input logic b);
    top = b ? x[7] : x[15];
  endfunction : top

  logic [15:0] mask, a, s, b, dec;
  logic [16:0] sum;
  logic [4:0] dig;
  logic [3:0] dcs;
  logic ci, sub, dc, c, v, logC;

  // ==========================================================
  // Arithmetic and logic
  always_comb begin
    mask = byteOp ? 16'h00FF : 16'hFFFF;
    a = dst & mask;
    s = src & mask;
    sub = opc == OP_SUBC || opc == OP_SUB || opc == OP_CMP;
    b = (sub ? ~src : src) & mask;
    ci = (opc == OP_ADDC || opc == OP_SUBC) ? cIn : sub;
    sum = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
    dc = cIn;
    dec = 16'h0000;
    dcs = 4'h0;
    for (int i = 0; i < 4; i++) begin
      dig = {1'b0, a[4*i+:4]} + {1'b0, s[4*i+:4]} + {4'h0, dc};
      if (dig > 5'h09) begin
        dig = dig + 5'h06;
      end
      dec[4*i+:4] = dig[3:0];
      dcs[i] = dig[4];
      dc = dig[4];
    end
    res = 16'h0000;
    wrEn = 1'b1;
    flagsEn = 1'b1;
    c = 1'b0;
    v = 1'b0;
    logC = 1'b0;
    if (fmt2) begin
      case (opc[2:0])
        OP_RRC, OP_RRA: begin
          res = a >> 1;
          if (byteOp) begin
            res[7] = (opc[2:0] == OP_RRC) ? cIn : a[7];
          end else begin
            res[15] = (opc[2:0] == OP_RRC) ? cIn : a[15];
          end
          c = a[0];
        end
        OP_SWPB: begin
          res = {dst[7:0], dst[15:8]};
          flagsEn = 1'b0;
        end
        OP_SXT: begin
          res = {{8{dst[7]}}, dst[7:0]};
          logC = 1'b1;
        end
        default: begin
          res = dst;
          wrEn = 1'b0;
          flagsEn = 1'b0;
        end
      endcase
    end else begin
      case (opc)
        OP_MOV: begin
          res = s;
          flagsEn = 1'b0;
        end
        OP_ADD, OP_ADDC, OP_SUBC, OP_SUB, OP_CMP: begin
          res = sum[15:0];
          c = byteOp ? sum[8] : sum[16];
          v = (top(a, byteOp) == top(b, byteOp)) && (top(res, byteOp) != top(a, byteOp));
          wrEn = opc != OP_CMP;
        end
        OP_DADD: begin
          res = dec;
          c = byteOp ? dcs[1] : dcs[3];
        end
        OP_BIT, OP_AND: begin
          res = a & s;
          logC = 1'b1;
          wrEn = opc == OP_AND;
        end
        OP_XOR: begin
          res = a ^ s;
          logC = 1'b1;
          v = top(a, byteOp) & top(s, byteOp);
        end
        OP_BIC: begin
          res = a & ~s;
          flagsEn = 1'b0;
        end
        OP_BIS: begin
          res = a | s;
          flagsEn = 1'b0;
        end
        default: begin
          wrEn = 1'b0;
          flagsEn = 1'b0;
        end
      endcase
    end
    res = res & mask;
    if (logC) begin
      c = res != 16'h0000;
    end
    flags = {v, top(res, byteOp), res == 16'h0000, c};
  end

endmodule : rcc_alu

// >>> rcc_core.sv
`timescale 1ns/100ps
`include "rcc_params.svh"

module rcc_core
  import rcc_pkg::*;
#(
  parameter logic [15:0] HOLE_LO = 16'hFFFF,
  parameter logic [15:0] HOLE_HI = 16'h0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] memRdata,
  output logic [15:0] memAddr,
  output logic [15:0] memWdata,
  output logic memRd,
  output logic memWr,
  output logic memByte,
  output logic sleepState,
  output logic fetchFault
);

  function automatic logic [15:0] regRd(input logic [15:0][15:0] rf, input logic [3:0] i,
                                        input logic [15:0] pcv);
    regRd = (i == `RCC_PC) ? pcv : rf[i];
  endfunction : regRd

  function automatic logic [15:0] rdSel(input logic [15:0] d, input logic odd, input logic b);
    rdSel = b ? {8'h00, odd ? d[15:8] : d[7:0]} : d;
  endfunction : rdSel

  function automatic logic [15:0] cgVal(input logic [3:0] i, input logic [1:0] m);
    if (i == `RCC_SR) begin
      cgVal = m[0] ? 16'h0008 : 16'h0004;
    end else begin
      case (m)
        2'b00: cgVal = 16'h0000;
        2'b01: cgVal = 16'h0001;
        2'b10: cgVal = 16'h0002;
        default: cgVal = 16'hFFFF;
      endcase
    end
  endfunction : cgVal

  localparam rcc_core_s RESET_S = '{state: ST_VEC, regs: '0, ir: '0, srcVal: '0, dstVal: '0,
                                    ea: '0, dea: '0, memAddr: `RCC_RESET_VECTOR, memWdata: '0,
                                    memRd: 1'b1, memWr: 1'b0, memByte: 1'b0, fault: 1'b0};

  rcc_core_s r, n;
  logic [15:0] instr, pcView, opSrc, opDst, res, target, wbAddr, sr;
  logic [3:0] opc, aluOpc, sReg, dReg, wbReg, aluFlags;
  logic [1:0] as;
  logic fmt1, fmt2, isJump, byteOp, cgHit, imm, sExt, sMem, dMem, direct, take;
  logic wbMem, wbOk, aluWr, aluFl, doExec, inHole;

  // ==========================================================
  // Decode
  always_comb begin
    instr = (r.state == ST_FETCH) ? memRdata : r.ir;
    pcView = (r.state == ST_FETCH) ? r.regs[`RCC_PC] + 16'h0002 : r.regs[`RCC_PC];
    sr = r.regs[`RCC_SR];
    opc = instr[15:12];
    isJump = instr[15:13] == 3'b001;
    fmt2 = instr[15:10] == 6'b000100;
    fmt1 = opc >= OP_MOV;
    byteOp = instr[6] & ~isJump;
    as = instr[5:4];
    sReg = fmt1 ? instr[11:8] : instr[3:0];
    dReg = instr[3:0];
    // Constant source: R3 in any mode, R2 in its two indirect modes
    cgHit = sReg == `RCC_CG || (sReg == `RCC_SR && as[1]);
    imm = sReg == `RCC_PC && as == 2'b11;
    sExt = (as == 2'b01 && sReg != `RCC_CG) || imm;
    sMem = ~cgHit && ~imm && as != 2'b00;
    dMem = fmt1 & instr[7];
    direct = (fmt1 | fmt2) & ~sExt & ~sMem & ~dMem;
    opSrc = (sExt | sMem) ? r.srcVal : (cgHit ? cgVal(sReg, as) : regRd(r.regs, sReg, pcView));
    opDst = fmt2 ? opSrc : (dMem ? r.dstVal : regRd(r.regs, dReg, pcView));
    aluOpc = fmt2 ? {1'b0, instr[9:7]} : opc;
    wbMem = fmt1 ? dMem : sMem;
    wbAddr = fmt1 ? r.dea : r.ea;
    wbReg = fmt1 ? dReg : sReg;
    wbOk = ~(fmt2 & (imm | cgHit));
    target = pcView + {{5{instr[9]}}, instr[9:0], 1'b0};
    case (instr[12:10])
      3'h0: take = ~sr[`RCC_SR_Z];
      3'h1: take = sr[`RCC_SR_Z];
      3'h2: take = ~sr[`RCC_SR_C];
      3'h3: take = sr[`RCC_SR_C];
      3'h4: take = sr[`RCC_SR_N];
      3'h5: take = ~(sr[`RCC_SR_N] ^ sr[`RCC_SR_V]);
      3'h6: take = sr[`RCC_SR_N] ^ sr[`RCC_SR_V];
      default: take = 1'b1;
    endcase
    inHole = r.regs[`RCC_PC] >= HOLE_LO && r.regs[`RCC_PC] <= HOLE_HI;
  end

  rcc_alu u_alu (
    .fmt2(fmt2),
    .opc(aluOpc),
    .byteOp(byteOp),
    .src(opSrc),
    .dst(opDst),
    .cIn(sr[`RCC_SR_C]),
    .res(res),
    .flags(aluFlags),
    .flagsEn(aluFl),
    .wrEn(aluWr)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    n = r;
    n.fault = 1'b0;
    doExec = 1'b0;
    case (r.state)
      ST_VEC: begin
        if (memRdata == `RCC_ERASED_WORD) begin
          n.regs[`RCC_SR] = sr | `RCC_SLEEP_BITS;
          n.state = ST_SLEEP;
        end else begin
          n.regs[`RCC_PC] = memRdata;
          n.state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        n.ir = memRdata;
        if (sr[`RCC_SR_OFF]) begin
          n.state = ST_SLEEP;
        end else if (r.regs[`RCC_PC] <= `RCC_PERIPH_TOP || inHole) begin
          n.fault = 1'b1;
          n.regs[`RCC_SR] = `RCC_SR_RESET;
          n.state = ST_VEC;
        end else begin
          n.regs[`RCC_PC] = pcView;
          if (isJump) begin
            if (take) begin
              n.regs[`RCC_PC] = target;
            end
          end else if (direct) begin
            doExec = 1'b1;
          end else if (sExt) begin
            n.state = ST_SEXT;
          end else if (sMem) begin
            n.ea = regRd(r.regs, sReg, pcView);
            n.state = ST_SRD;
          end else if (dMem) begin
            n.state = ST_DEXT;
          end
        end
      end
      ST_SEXT: begin
        n.regs[`RCC_PC] = r.regs[`RCC_PC] + 16'h0002;
        if (imm) begin
          n.srcVal = memRdata;
          n.state = dMem ? ST_DEXT : ST_EXEC;
        end else begin
          // Indexed, symbolic, or absolute when the base is R2
          n.ea = memRdata + ((sReg == `RCC_SR) ? 16'h0000 : regRd(r.regs, sReg, pcView));
          n.state = ST_SRD;
        end
      end
      ST_SRD: begin
        n.srcVal = rdSel(memRdata, r.ea[0], byteOp);
        if (as == 2'b11) begin
          n.regs[sReg] = r.regs[sReg] + ((byteOp && sReg != `RCC_SP) ? 16'h0001 : 16'h0002);
        end
        n.state = dMem ? ST_DEXT : ST_EXEC;
      end
      ST_DEXT: begin
        n.regs[`RCC_PC] = r.regs[`RCC_PC] + 16'h0002;
        n.dea = memRdata + ((dReg == `RCC_SR) ? 16'h0000 : regRd(r.regs, dReg, pcView));
        n.state = ST_DRD;
      end
      ST_DRD: begin
        n.dstVal = rdSel(memRdata, r.dea[0], byteOp);
        n.state = ST_EXEC;
      end
      ST_EXEC: begin
        doExec = 1'b1;
      end
      ST_MWR, ST_PUSH: begin
        n.state = ST_FETCH;
      end
      ST_SLEEP: begin
        n.state = ST_SLEEP;
      end
      default: begin
        n.state = ST_VEC;
      end
    endcase

    // Execute on the operands gathered so far
    if (doExec) begin
      n.state = ST_FETCH;
      if (fmt2 && (instr[9:7] == OP_PUSH || instr[9:7] == OP_CALL)) begin
        n.regs[`RCC_SP] = r.regs[`RCC_SP] - 16'h0002;
        n.dstVal = (instr[9:7] == OP_CALL) ? n.regs[`RCC_PC] : opSrc;
        if (instr[9:7] == OP_CALL) begin
          n.regs[`RCC_PC] = opSrc;
        end
        n.state = ST_PUSH;
      end else begin
        if (aluFl) begin
          n.regs[`RCC_SR] = {sr[15:9], aluFlags[3], sr[7:3], aluFlags[2:0]};
        end
        if (aluWr && wbOk) begin
          if (wbMem) begin
            n.dstVal = res;
            n.dea = wbAddr;
            n.state = ST_MWR;
          end else if (wbReg != `RCC_CG) begin
            n.regs[wbReg] = byteOp ? {8'h00, res[7:0]} : res;
          end
        end
      end
    end

    // Bus request for the state being entered
    n.memRd = 1'b1;
    n.memWr = 1'b0;
    n.memByte = 1'b0;
    n.memWdata = 16'h0000;
    n.memAddr = n.regs[`RCC_PC];
    case (n.state)
      ST_VEC: n.memAddr = `RCC_RESET_VECTOR;
      ST_SRD: n.memAddr = n.ea;
      ST_DRD: n.memAddr = n.dea;
      ST_MWR, ST_PUSH: begin
        n.memRd = 1'b0;
        n.memWr = 1'b1;
        n.memByte = byteOp;
        n.memAddr = (n.state == ST_MWR) ? n.dea : n.regs[`RCC_SP];
        n.memWdata = byteOp ? {n.dstVal[7:0], n.dstVal[7:0]} : n.dstVal;
      end
      ST_EXEC, ST_SLEEP: n.memRd = 1'b0;
      default: n.memRd = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= RESET_S;
    end else begin
      r <= n;
    end
  end

  assign memAddr = r.memAddr;
  assign memWdata = r.memWdata;
  assign memRd = r.memRd;
  assign memWr = r.memWr;
  assign memByte = r.memByte;
  assign sleepState = r.state == ST_SLEEP;
  assign fetchFault = r.fault;

endmodule : rcc_core

// >>> rcc_core_props.sv
`timescale 1ns/100ps
`include "rcc_params.svh"

module rcc_core_props
  import rcc_pkg::*;
#(
  parameter logic [15:0] HOLE_LO = 16'hFFFF,
  parameter logic [15:0] HOLE_HI = 16'h0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] memRdata,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic memByte,
  input wire logic sleepState,
  input wire logic fetchFault
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========
  // Start-up sequence
  sequence vecRead;
    $rose(rst_n) && memRd && memAddr == `RCC_RESET_VECTOR;
  endsequence

  sequence erasedVec;
    vecRead ##0 memRdata == `RCC_ERASED_WORD;
  endsequence

  sequence validVec;
    vecRead ##0 memRdata != `RCC_ERASED_WORD;
  endsequence

  vecStart_a: assert property ($rose(rst_n) |-> vecRead)
    else $error("vector read missing after reset");
  sleepEntry_a: assert property (erasedVec |=> sleepState)
    else $error("erased vector did not enter sleep");
  vecJump_a: assert property (validVec |=> memRd && memAddr == $past(memRdata))
    else $error("first fetch not at vector address");
  sleepQuiet_a: assert property (sleepState |-> !memRd && !memWr)
    else $error("bus active while asleep");
  sleepHold_a: assert property (sleepState |=> sleepState [*4])
    else $error("sleep left without reset");

  // ==========
  // Fetch faults and bus
  faultPulse_a: assert property (fetchFault |=> !fetchFault)
    else $error("fault pulse longer than one cycle");
  faultAddr_a: assert property (fetchFault |-> ($past(memAddr) <= `RCC_PERIPH_TOP)
    || ($past(memAddr) >= HOLE_LO && $past(memAddr) <= HOLE_HI))
    else $error("fault raised for a legal fetch");
  busExcl_a: assert property (!(memRd && memWr))
    else $error("read and write together");
  writeOne_a: assert property (memWr |=> !memWr)
    else $error("write held two cycles");
  byteLane_a: assert property (memWr && memByte |-> memWdata[15:8] == memWdata[7:0])
    else $error("byte write lanes differ");
endmodule : rcc_core_props

bind rcc_core rcc_core_props #(.HOLE_LO(HOLE_LO), .HOLE_HI(HOLE_HI)) u_props (
  .clk(clk), .rst_n(rst_n), .memRdata(memRdata), .memAddr(memAddr),
  .memWdata(memWdata), .memRd(memRd), .memWr(memWr), .memByte(memByte),
  .sleepState(sleepState), .fetchFault(fetchFault));

// >>> rcc_mem_model.sv
`timescale 1ns/100ps

module rcc_mem_model (
  input wire logic clk,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic memByte,
  output logic [15:0] memRdata
);
  logic [15:0] mem [0:32767];
  logic [15:0] lastData;

  initial begin
    lastData = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  // ==========
  // Shared bus for memory and peripherals
  always @(posedge clk) begin
    if (memRd) lastData <= mem[memAddr[15:1]];
    if (memWr && !memByte) mem[memAddr[15:1]] <= memWdata;
    if (memWr && memByte && memAddr[0]) mem[memAddr[15:1]][15:8] <= memWdata[15:8];
    if (memWr && memByte && !memAddr[0]) mem[memAddr[15:1]][7:0] <= memWdata[7:0];
  end

  // Idle bus shows no stale data
  assign memRdata = memRd ? mem[memAddr[15:1]] : ~lastData;
endmodule : rcc_mem_model

// >>> tb_top.sv
`timescale 1ns/100ps

module tb_top;
  import rcc_pkg::*;
  typedef struct {
    string name;
    logic [15:0] op;
    logic [15:0] exp;
  } rcc_row_s;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] memRdata;
  logic [15:0] memAddr;
  logic [15:0] memWdata;
  logic memRd;
  logic memWr;
  logic memByte;
  logic sleepState;
  logic fetchFault;
  logic seen;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] w [12];
  rcc_row_s rows [15] = '{'{"add", 16'h5405, 16'h4700}, '{"sub", 16'h8405, 16'h2118},
    '{"and", 16'hF405, 16'h1004}, '{"xor", 16'hE405, 16'h26F8},
    '{"bis", 16'hD405, 16'h36FC}, '{"bic", 16'hC405, 16'h2408},
    '{"movb", 16'h4445, 16'h00F4}, '{"addb", 16'h5445, 16'h0000},
    '{"subc", 16'h7405, 16'h2117}, '{"cmp", 16'h9405, 16'h340C},
    '{"bit", 16'hB405, 16'h340C}, '{"rrc", 16'h1005, 16'h1A06},
    '{"swpb", 16'h1085, 16'h0C34}, '{"rra", 16'h1105, 16'h1A06},
    '{"sxt", 16'h1185, 16'h000C}};

  // Unused range so that the hole check is reached
  rcc_core #(.HOLE_LO(16'h0400), .HOLE_HI(16'hBFFF)) u_rcc_core (.clk(clk), .rst_n(rst_n),
    .memRdata(memRdata), .memAddr(memAddr),
    .memWdata(memWdata), .memRd(memRd), .memWr(memWr), .memByte(memByte),
    .sleepState(sleepState), .fetchFault(fetchFault));
  rcc_mem_model u_mem (.clk(clk), .memAddr(memAddr), .memWdata(memWdata), .memRd(memRd),
    .memWr(memWr), .memByte(memByte), .memRdata(memRdata));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end

  // ==========
  // Helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic boot(input logic [15:0] vec, input int n);
    @(posedge clk);
    rst_n <= 1'b0;
    u_mem.mem[15'h7FFF] = vec;
    for (int i = 0; i < 12; i++) u_mem.mem[15'h6000 + i] = w[i];
    for (int i = 0; i < 3; i++) u_mem.mem[15'h0100 + i] = 16'h0000;
    repeat (10) @(posedge clk);
    chk("reset address", 16'hFFFE, memAddr);
    rst_n <= 1'b1;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : boot

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // ==========
  // Tests
  initial begin
    foreach (rows[i]) begin
      w = '{0: 16'h4034, 1: 16'h12F4, 2: 16'h4035, 3: 16'h340C, 4: rows[i].op,
        5: 16'h4582, 6: 16'h0200, default: 16'h3FFF};
      boot(16'hC000, 40);
      chk(rows[i].name, rows[i].exp, u_mem.mem[15'h0100]);
      $display("test %s done", rows[i].name);
    end
    w = '{0: 16'h4031, 1: 16'h0280, 2: 16'h4038, 3: 16'hC100, 4: 16'h1288,
      default: 16'h3FFF};
    u_mem.mem[15'h6080] = 16'h3FFF;
    boot(16'hC000, 40);
    chk("pushed return", 16'hC00A, u_mem.mem[15'h013F]);
    chk("call target", 16'hC100, memAddr);
    $display("test call done");
    w = '{0: 16'h403A, 1: 16'h0300, 2: 16'h4A3B, 3: 16'h4A3C, 4: 16'h4B82, 5: 16'h0200,
      6: 16'h4C82, 7: 16'h0202, 8: 16'h4BC2, 9: 16'h0204, default: 16'h3FFF};
    u_mem.mem[15'h0180] = 16'h1234;
    u_mem.mem[15'h0181] = 16'h5678;
    boot(16'hC000, 60);
    chk("first pop", 16'h1234, u_mem.mem[15'h0100]);
    chk("second pop", 16'h5678, u_mem.mem[15'h0101]);
    chk("byte store", 16'h0034, u_mem.mem[15'h0102]);
    $display("test autoincrement done");
    w = '{0: 16'h4034, 1: 16'h0005, 2: 16'h9404, 3: 16'h2002, 4: 16'h4482, 5: 16'h0200,
      6: 16'h5404, 7: 16'h2002, 8: 16'h4482, 9: 16'h0202, default: 16'h3FFF};
    boot(16'hC000, 60);
    chk("jump not taken", 16'h0005, u_mem.mem[15'h0100]);
    chk("jump taken", 16'h0000, u_mem.mem[15'h0101]);
    $display("test unequal jump done");
    boot(16'hFFFF, 6);
    chk("sleep state", 16'h0001, {15'h0000, sleepState});
    chk("sleep read", 16'h0000, {15'h0000, memRd});
    $display("test erased vector done");
    for (int k = 0; k < 2; k++) begin
      boot((k == 0) ? 16'h0100 : 16'h8000, 0);
      seen = 1'b0;
      repeat (20) begin
        @(negedge clk);
        if (fetchFault === 1'b1) seen = 1'b1;
      end
      chk("fetch fault", 16'h0001, {15'h0000, seen});
      $display("test fetch fault done");
    end
    final_report();
  end
endmodule : tb_top
